// ---- qbsp_ports.sv ----
// read and write port logic of a four-word ddr burst sram
`timescale 1ns/1ps
`include "qbsp_consts.svh"

// Functional notes
// - pll pin high: read data starts two and a half cycles after request
// - pll pin low: legacy mode, read data one cycle after request
// - reads and writes start only on positive clock edges
// - port selects are sampled at positive edges only; byte selects at both clock edge kinds
// - read data launched from registers, write data registered, on both edges
// - each access moves four 18-bit words over two cycles
// - read starts on sampled read select; address kept in read register
// - first read word driven at the third following negative edge (pll mode)
// - following words driven on each next edge until four are out
// - read select on consecutive positive edges: second read dropped
// - reads every other positive edge stream out without gaps
// - deselected read port first finishes pending bursts
// - read outputs go high impedance after the next negative edge
// - write starts on sampled write select; address latched
// - first write word captured at next positive edge if byte selects low
// - second write word captured at following negative edge likewise
// - four words collected then committed at the latched address
// - write select on consecutive positive edges: second write ignored
// - writes every other positive edge take one word per edge
// - deselected write port completes pending burst then ignores inputs
// - burst covers latched address and next three sequential locations
// - both selects held from idle alternate read and write, read first
// - after reset deselected with read outputs high impedance
module qbsp_ports (
    input  wire logic                 MCLK,
    input  wire logic                 RESET_N,
    input  wire logic                 CE,
    input  wire logic                 PLL_DISABLE_N,
    input  wire logic                 READ_PORT_SELECT_N,
    input  wire logic                 WRITE_PORT_SELECT_N,
    input  wire logic [1:0]           BYTE_WRITE_SELECT_N,
    input  wire qbsp_pkg::qbsp_addr_t ADDR,
    input  wire qbsp_pkg::qbsp_word_t D,
    output logic                      K_PHASE,
    output qbsp_pkg::qbsp_word_t      Q,
    output logic                      Q_OE
);

    ////////////////////////////////////////////////////////////////////////
    // storage and state

    qbsp_pkg::qbsp_word_t mem [0:(1 << (`QBSP_ADDR_W + 2)) - 1];
    qbsp_pkg::qbsp_word_t line_q [0:`QBSP_BURST-1];
    qbsp_pkg::qbsp_word_t wbuf_q [0:`QBSP_BURST-1];
    logic [`QBSP_BURST-1:0] wen_q;
    qbsp_pkg::qbsp_addr_t   rd_addr_q;
    qbsp_pkg::qbsp_addr_t   wr_addr_q;
    qbsp_pkg::qbsp_addr_t   wc_addr_q;
    qbsp_pkg::qbsp_dl_t     rd_dl_q;
    qbsp_pkg::qbsp_dl_t     wr_dl_q;
    logic                   neg_q;
    logic                   last_rd_q;
    logic                   last_wr_q;
    logic [2:0]             lat_q;
    logic [2:0]             pll_s_q;
    logic                   k_edge;
    logic                   rd_go;
    logic                   wr_go;
    logic                   word_act;
    logic [1:0]             word_k;
    logic                   fetch;
    logic                   commit;
    logic                   bws_ok;

    // burst word address: latched line address plus word offset
    function automatic qbsp_pkg::qbsp_waddr_t qbsp_wa(input qbsp_pkg::qbsp_addr_t a, input int k);
        qbsp_wa = {a, k[1:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // edge phase: each mclk edge is a positive or negative input clock rise

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            neg_q <= 1'b0;
        end else if (CE) begin
            neg_q <= ~neg_q;
        end
    end

    assign k_edge  = ~neg_q;
    assign K_PHASE = k_edge;

    // latency strap: three flops, taken once the last two agree
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pll_s_q <= 3'h7; // pin-high level, so no false mode change after reset
            lat_q   <= `QBSP_LAT_PLL;
        end else if (CE) begin
            pll_s_q <= {pll_s_q[1:0], PLL_DISABLE_N};
            if (pll_s_q[1] == pll_s_q[2]) begin
                lat_q <= pll_s_q[2] ? `QBSP_LAT_PLL : `QBSP_LAT_LEGACY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request acceptance and arbitration

    // selects sampled at the edge; reads win unless a read just started
    assign rd_go  = k_edge & ~READ_PORT_SELECT_N & ~last_rd_q;
    assign wr_go  = k_edge & ~WRITE_PORT_SELECT_N & ~last_wr_q & ~rd_go;
    assign bws_ok = (BYTE_WRITE_SELECT_N == `QBSP_BWS_ALL);

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            last_rd_q <= 1'b0;
            last_wr_q <= 1'b0;
        end else if (CE && k_edge) begin
            last_rd_q <= rd_go;
            last_wr_q <= wr_go;
        end
    end

    // start delay lines, bit i set when a start was i+1 edges ago
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_dl_q <= '0;
            wr_dl_q <= '0;
        end else if (CE) begin
            rd_dl_q <= {rd_dl_q[`QBSP_DL_W-2:0], rd_go};
            wr_dl_q <= {wr_dl_q[`QBSP_DL_W-2:0], wr_go};
        end
    end

    // separate address registers per port
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_addr_q <= '0;
            wr_addr_q <= '0;
            wc_addr_q <= '0;
        end else if (CE) begin
            if (rd_go) begin
                rd_addr_q <= ADDR;
            end
            if (wr_go) begin
                wr_addr_q <= ADDR;
            end
            if (wr_dl_q[`QBSP_WR_FIRST]) begin
                wc_addr_q <= wr_addr_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    assign fetch = rd_dl_q[lat_q - 3'h2];

    always_comb begin
        word_act = 1'b0;
        word_k   = 2'h0;
        for (int k = 0; k < `QBSP_BURST; k++) begin
            if (rd_dl_q[lat_q - 3'h1 + k[2:0]]) begin
                word_act = 1'b1;
                word_k   = k[1:0];
            end
        end
    end

    // fetch the whole line one edge before its first word leaves
    always_ff @(posedge MCLK) begin
        if (CE && fetch) begin
            for (int k = 0; k < `QBSP_BURST; k++) begin
                line_q[k] <= mem[qbsp_wa(rd_addr_q, k)];
            end
        end
    end

    // output register; enable only falls on a negative edge
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            Q    <= '0;
            Q_OE <= 1'b0;
        end else if (CE) begin
            if (word_act) begin
                Q <= line_q[word_k];
            end
            Q_OE <= word_act | (Q_OE & k_edge);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write path

    assign commit = wr_dl_q[`QBSP_WR_LAST];

    // collect the first three words, then commit all four
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wen_q <= '0;
        end else if (CE) begin
            for (int k = 0; k < `QBSP_BURST - 1; k++) begin
                if (wr_dl_q[`QBSP_WR_FIRST + k[2:0]]) begin
                    wen_q[k] <= bws_ok;
                end
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (CE) begin
            for (int k = 0; k < `QBSP_BURST - 1; k++) begin
                if (wr_dl_q[`QBSP_WR_FIRST + k[2:0]]) begin
                    wbuf_q[k] <= D;
                end
            end
            if (commit) begin
                for (int k = 0; k < `QBSP_BURST - 1; k++) begin
                    if (wen_q[k]) begin
                        mem[qbsp_wa(wc_addr_q, k)] <= wbuf_q[k];
                    end
                end
                if (bws_ok) begin
                    mem[qbsp_wa(wc_addr_q, `QBSP_BURST - 1)] <= D;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_start_k;
        @(posedge MCLK) disable iff (!RESET_N) (rd_go || wr_go) |-> k_edge;
    endproperty
    a_start_k: assert property (p_start_k) else $error("start on negative edge");

    property p_rd_gap;
        @(posedge MCLK) disable iff (!RESET_N || !CE) rd_go ##1 CE [*2] |-> !rd_go;
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("back to back read accepted");

    property p_wr_gap;
        @(posedge MCLK) disable iff (!RESET_N || !CE) wr_go ##1 CE [*2] |-> !wr_go;
    endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("back to back write accepted");

    property p_lat_pll;
        @(posedge MCLK) disable iff (!RESET_N || !CE) (rd_go && lat_q == `QBSP_LAT_PLL) |-> ##6 Q_OE [*4];
    endproperty
    a_lat_pll: assert property (p_lat_pll) else $error("pll mode read latency wrong");

    property p_lat_legacy;
        @(posedge MCLK) disable iff (!RESET_N || !CE) (rd_go && lat_q == `QBSP_LAT_LEGACY) |-> ##3 Q_OE [*4];
    endproperty
    a_lat_legacy: assert property (p_lat_legacy) else $error("legacy mode read latency wrong");

    property p_hiz_neg;
        @(posedge MCLK) disable iff (!RESET_N || !CE) $fell(Q_OE) |-> !$past(k_edge);
    endproperty
    a_hiz_neg: assert property (p_hiz_neg) else $error("outputs released off a negative edge");

    property p_alternate;
        @(posedge MCLK) disable iff (!RESET_N || !CE) (rd_go ##2 (!WRITE_PORT_SELECT_N && !last_wr_q)) |-> wr_go;
    endproperty
    a_alternate: assert property (p_alternate) else $error("write not granted after read");

    property p_commit;
        @(posedge MCLK) disable iff (!RESET_N || !CE) wr_go |-> ##5 commit;
    endproperty
    a_commit: assert property (p_commit) else $error("write not committed after four words");

    property p_one_start;
        @(posedge MCLK) disable iff (!RESET_N) !(rd_go && wr_go);
    endproperty
    a_one_start: assert property (p_one_start) else $error("read and write started together");

    // address capture into the port's own register
    property p_rd_addr;
        @(posedge MCLK) disable iff (!RESET_N || !CE) rd_go |=> (rd_addr_q == $past(ADDR));
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read address not captured");

    property p_wr_addr;
        @(posedge MCLK) disable iff (!RESET_N || !CE) wr_go |=> (wr_addr_q == $past(ADDR));
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("write address not captured");

    // burst words leave in order, one per edge
    property p_word_seq;
        @(posedge MCLK) disable iff (!RESET_N || !CE)
            (word_act && word_k != 2'h3) |=> (word_act && word_k == $past(word_k) + 2'h1);
    endproperty
    a_word_seq: assert property (p_word_seq) else $error("read words out of order");

    // clock enable low holds phase and outputs
    property p_freeze;
        @(posedge MCLK) disable iff (!RESET_N) !CE |=> ($stable(neg_q) && $stable(Q) && $stable(Q_OE));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

    c_legacy_read: cover property (@(posedge MCLK) rd_go && lat_q == `QBSP_LAT_LEGACY);
    c_stream_read: cover property (@(posedge MCLK) rd_go ##4 rd_go);
    c_alternate:   cover property (@(posedge MCLK) rd_go ##2 wr_go ##2 rd_go);
    c_pipe_write:  cover property (@(posedge MCLK) wr_go ##4 wr_go);
    c_freeze:      cover property (@(posedge MCLK) !CE ##1 CE);

endmodule

// ---- qbsp_consts.svh ----
// named constants for the burst sram port logic
`ifndef QBSP_CONSTS_SVH
`define QBSP_CONSTS_SVH

`define QBSP_WORD_W     18
`define QBSP_ADDR_W     20
`define QBSP_BURST      4
`define QBSP_DL_W       8
`define QBSP_LAT_PLL    3'h5
`define QBSP_LAT_LEGACY 3'h2
`define QBSP_WR_FIRST   3'h1
`define QBSP_WR_LAST    3'h4
`define QBSP_BWS_ALL    2'h0

`endif

// ---- qbsp_pkg.sv ----
// types shared by the burst sram port logic
`include "qbsp_consts.svh"

package qbsp_pkg;
    typedef logic [`QBSP_WORD_W-1:0] qbsp_word_t;
    typedef logic [`QBSP_ADDR_W-1:0] qbsp_addr_t;
    typedef logic [`QBSP_ADDR_W+1:0] qbsp_waddr_t;
    typedef logic [`QBSP_DL_W-1:0]   qbsp_dl_t;
endpackage

// ---- qbsp_ctl.sv ----
// memory controller model driving the sram request pins
`timescale 1ns/1ps
module qbsp_ctl (
    input  wire logic            MCLK,
    output logic                 rps_n,
    output logic                 wps_n,
    output logic [1:0]           bws_n,
    output qbsp_pkg::qbsp_addr_t adr,
    output qbsp_pkg::qbsp_word_t d
);
    // quiet pins at time zero
    initial begin
        rps_n = 1'b1;
        wps_n = 1'b1;
        bws_n = 2'h3;
        adr = 20'h00000;
        d = 18'h00000;
    end
    // one clock edge of stimulus, set on the falling clock
    task automatic step(input logic r, input logic w, input logic [1:0] b,
                        input qbsp_pkg::qbsp_addr_t a, input qbsp_pkg::qbsp_word_t v);
        @(negedge MCLK);
        rps_n = ~r;
        wps_n = ~w;
        bws_n = b;
        adr = a;
        d = v;
    endtask
    // released lines keep toggling, never the last value
    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b0, 2'h3, ~adr, ~d);
    endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the burst sram port logic
`timescale 1ns/1ps
module testbench;
    logic                 mclk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 pll_disable_n = 1'b1;
    logic                 ce = 1'b1;
    bit                   wn;
    logic                 rps_n, wps_n, k_phase, q_oe, kph, lrd, lwr, rd, wr;
    logic [1:0]           bws_n;
    qbsp_pkg::qbsp_addr_t adr, wa[2];
    qbsp_pkg::qbsp_word_t din, q, wb[8], mem[int], exp_q[4096];
    bit                   wm[8], exp_oe[4096], exp_v[4096];
    int                   e, ws[2], lat, cyc, n_mismatch, compares;

    always #12.5 mclk = ~mclk;

    qbsp_ctl ctl (.MCLK(mclk), .rps_n(rps_n), .wps_n(wps_n), .bws_n(bws_n), .adr(adr), .d(din));
    qbsp_ports dut (.MCLK(mclk), .RESET_N(reset_n), .CE(ce), .PLL_DISABLE_N(pll_disable_n),
        .READ_PORT_SELECT_N(rps_n), .WRITE_PORT_SELECT_N(wps_n), .BYTE_WRITE_SELECT_N(bws_n),
        .ADDR(adr), .D(din), .K_PHASE(k_phase), .Q(q), .Q_OE(q_oe));

    function automatic int key(input qbsp_pkg::qbsp_addr_t a, input int k);
        return int'({a, k[1:0]});
    endfunction

    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        compares++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reference: acceptance, read schedule and memory image
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            kph = 1'b1;
            lrd = 1'b0;
            lwr = 1'b0;
            ws = '{-100, -100};
        end else if (ce) begin
            e++;
            if (kph) begin
                rd = !rps_n && !lrd;
                wr = !wps_n && !lwr && !rd;
                lrd = rd;
                lwr = wr;
                lat = pll_disable_n ? 5 : 2;
                for (int k = 0; rd && k < 5; k++) begin
                    exp_oe[e + lat + k] = k < 4 || lat == 2;
                    exp_v[e + lat + k] = k < 4 && mem.exists(key(adr, k));
                    if (exp_v[e + lat + k]) exp_q[e + lat + k] = mem[key(adr, k)];
                end
                if (wr) begin
                    ws[wn] = e;
                    wa[wn] = adr;
                    wn = !wn;
                end
            end
            kph = !kph;
            // two write slots, since pipelined bursts overlap by two edges
            for (int j = 0; j < 2; j++) begin
                if (e - ws[j] inside {[2:5]}) begin
                    wm[4 * j + e - ws[j] - 2] = bws_n === 2'h0;
                    wb[4 * j + e - ws[j] - 2] = din;
                end
                for (int k = 0; e - ws[j] == 5 && k < 4; k++)
                    if (wm[4 * j + k]) mem[key(wa[j], k)] = wb[4 * j + k];
            end
        end
    end

    // compare outputs once settled after each edge
    always @(negedge mclk) begin
        if (reset_n && e > 0) begin
            check(k_phase, kph);
            check(q_oe, exp_oe[e]);
            if (exp_v[e]) check(q, exp_q[e]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr_burst(input qbsp_pkg::qbsp_addr_t a, input qbsp_pkg::qbsp_word_t v,
                            input logic [1:0] b1);
        ctl.step(1'b0, 1'b1, 2'h3, a, ~din);
        ctl.idle(1);
        for (int k = 0; k < 4; k++) ctl.step(1'b0, 1'b0, k == 1 ? b1 : 2'h0, ~adr, v + 18'(k));
    endtask
    task automatic rd_req(input qbsp_pkg::qbsp_addr_t a, input int gap);
        ctl.step(1'b1, 1'b0, 2'h3, a, ~din);
        ctl.idle(gap);
    endtask
    // write two lines and read both back
    task automatic t_basic;
        wr_burst(20'h00012, 18'h10000, 2'h0);
        wr_burst(20'h00034, 18'h20000, 2'h0);
        rd_req(20'h00012, 3);
        rd_req(20'h00034, 11);
    endtask
    // second word masked keeps the old word
    task automatic t_mask;
        wr_burst(20'h00012, 18'h30000, 2'h1);
        rd_req(20'h00012, 11);
    endtask
    // requests on consecutive positive edges
    task automatic t_b2b;
        rd_req(20'h00012, 1);
        rd_req(20'h00034, 11);
        ctl.step(1'b0, 1'b1, 2'h3, 20'h00034, ~din);
        ctl.idle(1);
        for (int k = 0; k < 4; k++) ctl.step(1'b0, k == 0, 2'h0, 20'h00012, 18'h3f000 + 18'(k));
        rd_req(20'h00034, 3);
        rd_req(20'h00012, 11);
    endtask
    // both selects held from idle
    task automatic t_alt;
        for (int i = 0; i < 12; i++) ctl.step(i < 8, i < 8, 2'h0, 20'h00100 + 20'(i), 18'h2a000 + 18'(i));
        rd_req(20'h00102, 3);
        rd_req(20'h00106, 11);
    endtask
    // clock enable low mid burst: state frozen, selects ignored
    task automatic t_freeze;
        ctl.step(1'b1, 1'b0, 2'h3, 20'h00034, ~din);
        ctl.idle(4);
        ce = 1'b0;
        ctl.step(1'b1, 1'b1, 2'h0, 20'h00012, 18'h15555);
        ctl.idle(1);
        ce = 1'b1;
        ctl.idle(5);
    endtask
    // one cycle latency mode
    task automatic t_legacy;
        pll_disable_n = 1'b0;
        ctl.idle(6);
        rd_req(20'h00012, 3);
        rd_req(20'h00034, 11);
        pll_disable_n = 1'b1;
        ctl.idle(7);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            summarize();
        end
    end

    // main sequence
    initial begin
        repeat (10) @(negedge mclk);
        check(q_oe, 1'b0);
        check(k_phase, 1'b1);
        reset_n = 1'b1;
        ctl.idle(1);
        t_basic();
        t_mask();
        t_b2b();
        t_alt();
        t_freeze();
        t_legacy();
        summarize();
    end
endmodule
